// ### src/gdt_pkg.sv
// package of offsets, fields and reset values for the gate drive timing registers
package gdt_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_DRIVE_TIMING = 5'h0d;
    localparam logic [4:0] OFS_DELAY_CH1 = 5'h0e;
    localparam logic [4:0] OFS_DELAY_CH2 = 5'h0f;
    localparam logic [4:0] OFS_DELAY_CH3 = 5'h10;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_FW_DRIVE_TIMING = 16'h4900;
    localparam logic [15:0] RST_ACT_DRIVE_TIMING = 16'h4900;
    localparam logic [15:0] RST_SWITCH_DELAYS = 16'h0a0a;
    // ------------------------------------------------------------
    // field layout of the drive current and timing register
    // ------------------------------------------------------------
    localparam int RESERVED_BIT = 15;
    localparam int BLANK4_LSB = 12;
    localparam int CCP4_LSB = 9;
    localparam int BLANK3_LSB = 6;
    localparam int ICH1_LSB = 0;
    localparam int ICH2_LSB = 2;
    localparam int ICH3_LSB = 4;
    localparam logic [15:0] DRIVE_TIMING_WMASK = 16'h7fff;
    // ------------------------------------------------------------
    // delay register fields and step
    // ------------------------------------------------------------
    localparam int TOFF_LSB = 8;
    localparam int TON_LSB = 0;
    localparam real DELAY_STEP_NS = 62.5;
    localparam real CLK_PERIOD_NS = 4.0;
    localparam int DELAY_STEP_CYC = int'(DELAY_STEP_NS / CLK_PERIOD_NS);
endpackage

// ### src/gdt_regs.sv
// register slice holding freewheel and active timing plus per-channel switch delays
// How it works
// (R1) bank bit 1 at offset 0x0d reaches the freewheel drive current and timing register
// (R2) bank bit 0 at offset 0x0d reaches the active-side timing register instead
// (R3) bank-1 blanking and cross-conduction times drive only freewheel transistor outputs
// (R4) bit 15 of the bank-1 register always reads zero
// (R5) bits 14:12 freewheel blanking set 4, reset code 100
// (R6) bits 11:9 freewheel cross-conduction set 4, reset code 100
// (R7) bits 8:6 freewheel blanking set 3, reset code 100
// (R8) bits 1:0, 3:2, 5:4 max drive current of channels 1, 2, 3
// (R9) current codes ascend from 00 lowest (reset) to 11 highest
// (R10) max current select also used during post-charge of modulated transistor
// (R11) bridge-to-set mapping lives elsewhere; sets are exported unmapped
// (R12) delay bits 15:8 hold turn-off delay count in 62.5 ns steps
// (R13) delay bits 7:0 hold turn-on delay count in 62.5 ns steps
// (R14) both delay fields of every channel reset to 0x0a
// (R15) channel delay registers sit at offsets 0x0e, 0x0f, 0x10
// (R16) writes to bank-1 bit 15 are dropped
`timescale 1ns/10ps
module gdt_regs (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reg_bank,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_hit,
    output logic [2:0] freewheel_blanking_set4,
    output logic [2:0] freewheel_cross_conduction_set4,
    output logic [2:0] freewheel_blanking_set3,
    output logic [2:0] active_blanking_set4,
    output logic [2:0] active_cross_conduction_set4,
    output logic [2:0] active_blanking_set3,
    output logic [1:0] max_drive_current_ch1,
    output logic [1:0] max_drive_current_ch2,
    output logic [1:0] max_drive_current_ch3,
    output logic [7:0] turn_on_delay_ch1,
    output logic [7:0] turn_on_delay_ch2,
    output logic [7:0] turn_on_delay_ch3,
    output logic [7:0] turn_off_delay_ch1,
    output logic [7:0] turn_off_delay_ch2,
    output logic [7:0] turn_off_delay_ch3
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] fw_r;
    logic [15:0] fw_nxt;
    logic [15:0] act_r;
    logic [15:0] act_nxt;
    logic [15:0] dly_r [3];
    logic [15:0] dly_nxt [3];
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic hit_r;
    logic hit_nxt;

    // ------------------------------------------------------------
    // offset decode and qualified strobes
    // ------------------------------------------------------------
    logic sel_fw;
    logic sel_act;
    logic sel_dly1;
    logic sel_dly2;
    logic sel_dly3;
    logic sel_any;
    logic wr_fw;
    logic wr_act;
    logic wr_dly1;
    logic wr_dly2;
    logic wr_dly3;

    // ------------------------------------------------------------
    // field output registers
    // ------------------------------------------------------------
    logic [2:0] fw_blank4_r;
    logic [2:0] fw_blank4_nxt;
    logic [2:0] fw_xcond4_r;
    logic [2:0] fw_xcond4_nxt;
    logic [2:0] fw_blank3_r;
    logic [2:0] fw_blank3_nxt;
    logic [2:0] act_blank4_r;
    logic [2:0] act_blank4_nxt;
    logic [2:0] act_xcond4_r;
    logic [2:0] act_xcond4_nxt;
    logic [2:0] act_blank3_r;
    logic [2:0] act_blank3_nxt;
    logic [1:0] imax1_r;
    logic [1:0] imax1_nxt;
    logic [1:0] imax2_r;
    logic [1:0] imax2_nxt;
    logic [1:0] imax3_r;
    logic [1:0] imax3_nxt;
    logic [7:0] ton1_r;
    logic [7:0] ton1_nxt;
    logic [7:0] ton2_r;
    logic [7:0] ton2_nxt;
    logic [7:0] ton3_r;
    logic [7:0] ton3_nxt;
    logic [7:0] toff1_r;
    logic [7:0] toff1_nxt;
    logic [7:0] toff2_r;
    logic [7:0] toff2_nxt;
    logic [7:0] toff3_r;
    logic [7:0] toff3_nxt;

    // ------------------------------------------------------------
    // offset decode, bank bit steers the shared offset
    // ------------------------------------------------------------
    always_comb begin
        sel_fw = 1'b0;
        sel_act = 1'b0;
        sel_dly1 = 1'b0;
        sel_dly2 = 1'b0;
        sel_dly3 = 1'b0;
        sel_any = 1'b1;
        if (reg_addr == gdt_pkg::OFS_DRIVE_TIMING && reg_bank) begin
            sel_fw = 1'b1; // [R1]
        end else if (reg_addr == gdt_pkg::OFS_DRIVE_TIMING) begin
            sel_act = 1'b1; // [R2]
        end else if (reg_addr == gdt_pkg::OFS_DELAY_CH1) begin
            sel_dly1 = 1'b1; // [R15]
        end else if (reg_addr == gdt_pkg::OFS_DELAY_CH2) begin
            sel_dly2 = 1'b1; // [R15]
        end else if (reg_addr == gdt_pkg::OFS_DELAY_CH3) begin
            sel_dly3 = 1'b1; // [R15]
        end else begin
            sel_any = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // write strobes, unmapped offsets get none
    // ------------------------------------------------------------
    always_comb begin
        wr_fw = reg_wr & sel_fw;
        wr_act = reg_wr & sel_act;
        wr_dly1 = reg_wr & sel_dly1;
        wr_dly2 = reg_wr & sel_dly2;
        wr_dly3 = reg_wr & sel_dly3;
    end

    // ------------------------------------------------------------
    // register contents, next values
    // ------------------------------------------------------------
    always_comb begin
        fw_nxt = fw_r;
        act_nxt = act_r;
        dly_nxt[0] = dly_r[0];
        dly_nxt[1] = dly_r[1];
        dly_nxt[2] = dly_r[2];
        if (wr_fw) begin
            fw_nxt = reg_wdata & gdt_pkg::DRIVE_TIMING_WMASK; // [R1] [R16]
        end
        if (wr_act) begin
            act_nxt = reg_wdata & gdt_pkg::DRIVE_TIMING_WMASK; // [R2]
        end
        if (wr_dly1) begin
            dly_nxt[0] = reg_wdata; // [R15]
        end
        if (wr_dly2) begin
            dly_nxt[1] = reg_wdata; // [R15]
        end
        if (wr_dly3) begin
            dly_nxt[2] = reg_wdata; // [R15]
        end
    end

    // ------------------------------------------------------------
    // register contents, storage
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fw_r <= gdt_pkg::RST_FW_DRIVE_TIMING; // [R5] [R6] [R7] [R9]
            act_r <= gdt_pkg::RST_ACT_DRIVE_TIMING;
            dly_r[0] <= gdt_pkg::RST_SWITCH_DELAYS; // [R14]
            dly_r[1] <= gdt_pkg::RST_SWITCH_DELAYS; // [R14]
            dly_r[2] <= gdt_pkg::RST_SWITCH_DELAYS; // [R14]
        end else begin
            fw_r <= fw_nxt;
            act_r <= act_nxt;
            dly_r[0] <= dly_nxt[0];
            dly_r[1] <= dly_nxt[1];
            dly_r[2] <= dly_nxt[2];
        end
    end

    // ------------------------------------------------------------
    // read data, old contents when read and write coincide
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = rdata_r;
        hit_nxt = 1'b0;
        if (reg_rd) begin
            hit_nxt = sel_any; // [R15]
            if (sel_fw) begin
                rdata_nxt = fw_r & gdt_pkg::DRIVE_TIMING_WMASK; // [R4]
            end else if (sel_act) begin
                rdata_nxt = act_r & gdt_pkg::DRIVE_TIMING_WMASK; // [R2]
            end else if (sel_dly1) begin
                rdata_nxt = dly_r[0]; // [R15]
            end else if (sel_dly2) begin
                rdata_nxt = dly_r[1]; // [R15]
            end else if (sel_dly3) begin
                rdata_nxt = dly_r[2]; // [R15]
            end else begin
                rdata_nxt = 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // read data, storage
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_r <= 16'h0000;
            hit_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            hit_r <= hit_nxt;
        end
    end

    // ------------------------------------------------------------
    // field outputs, next values
    // ------------------------------------------------------------
    always_comb begin
        fw_blank4_nxt = fw_r[gdt_pkg::BLANK4_LSB +: 3]; // [R3] [R5] [R11]
        fw_xcond4_nxt = fw_r[gdt_pkg::CCP4_LSB +: 3]; // [R3] [R6]
        fw_blank3_nxt = fw_r[gdt_pkg::BLANK3_LSB +: 3]; // [R3] [R7]
        act_blank4_nxt = act_r[gdt_pkg::BLANK4_LSB +: 3]; // [R2]
        act_xcond4_nxt = act_r[gdt_pkg::CCP4_LSB +: 3]; // [R2]
        act_blank3_nxt = act_r[gdt_pkg::BLANK3_LSB +: 3]; // [R2]
        imax1_nxt = fw_r[gdt_pkg::ICH1_LSB +: 2]; // [R8] [R9] [R10]
        imax2_nxt = fw_r[gdt_pkg::ICH2_LSB +: 2]; // [R8] [R9] [R10]
        imax3_nxt = fw_r[gdt_pkg::ICH3_LSB +: 2]; // [R8] [R9] [R10]
        ton1_nxt = dly_r[0][gdt_pkg::TON_LSB +: 8]; // [R13]
        ton2_nxt = dly_r[1][gdt_pkg::TON_LSB +: 8]; // [R13]
        ton3_nxt = dly_r[2][gdt_pkg::TON_LSB +: 8]; // [R13]
        toff1_nxt = dly_r[0][gdt_pkg::TOFF_LSB +: 8]; // [R12]
        toff2_nxt = dly_r[1][gdt_pkg::TOFF_LSB +: 8]; // [R12]
        toff3_nxt = dly_r[2][gdt_pkg::TOFF_LSB +: 8]; // [R12]
    end

    // ------------------------------------------------------------
    // field outputs, one register stage each
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fw_blank4_r <= gdt_pkg::RST_FW_DRIVE_TIMING[gdt_pkg::BLANK4_LSB +: 3];
            fw_xcond4_r <= gdt_pkg::RST_FW_DRIVE_TIMING[gdt_pkg::CCP4_LSB +: 3];
            fw_blank3_r <= gdt_pkg::RST_FW_DRIVE_TIMING[gdt_pkg::BLANK3_LSB +: 3];
            act_blank4_r <= gdt_pkg::RST_ACT_DRIVE_TIMING[gdt_pkg::BLANK4_LSB +: 3];
            act_xcond4_r <= gdt_pkg::RST_ACT_DRIVE_TIMING[gdt_pkg::CCP4_LSB +: 3];
            act_blank3_r <= gdt_pkg::RST_ACT_DRIVE_TIMING[gdt_pkg::BLANK3_LSB +: 3];
            imax1_r <= gdt_pkg::RST_FW_DRIVE_TIMING[gdt_pkg::ICH1_LSB +: 2];
            imax2_r <= gdt_pkg::RST_FW_DRIVE_TIMING[gdt_pkg::ICH2_LSB +: 2];
            imax3_r <= gdt_pkg::RST_FW_DRIVE_TIMING[gdt_pkg::ICH3_LSB +: 2];
            ton1_r <= gdt_pkg::RST_SWITCH_DELAYS[gdt_pkg::TON_LSB +: 8];
            ton2_r <= gdt_pkg::RST_SWITCH_DELAYS[gdt_pkg::TON_LSB +: 8];
            ton3_r <= gdt_pkg::RST_SWITCH_DELAYS[gdt_pkg::TON_LSB +: 8];
            toff1_r <= gdt_pkg::RST_SWITCH_DELAYS[gdt_pkg::TOFF_LSB +: 8];
            toff2_r <= gdt_pkg::RST_SWITCH_DELAYS[gdt_pkg::TOFF_LSB +: 8];
            toff3_r <= gdt_pkg::RST_SWITCH_DELAYS[gdt_pkg::TOFF_LSB +: 8];
        end else begin
            fw_blank4_r <= fw_blank4_nxt;
            fw_xcond4_r <= fw_xcond4_nxt;
            fw_blank3_r <= fw_blank3_nxt;
            act_blank4_r <= act_blank4_nxt;
            act_xcond4_r <= act_xcond4_nxt;
            act_blank3_r <= act_blank3_nxt;
            imax1_r <= imax1_nxt;
            imax2_r <= imax2_nxt;
            imax3_r <= imax3_nxt;
            ton1_r <= ton1_nxt;
            ton2_r <= ton2_nxt;
            ton3_r <= ton3_nxt;
            toff1_r <= toff1_nxt;
            toff2_r <= toff2_nxt;
            toff3_r <= toff3_nxt;
        end
    end

    // ------------------------------------------------------------
    // output ports, straight from the registers
    // ------------------------------------------------------------
    assign freewheel_blanking_set4 = fw_blank4_r;
    assign freewheel_cross_conduction_set4 = fw_xcond4_r;
    assign freewheel_blanking_set3 = fw_blank3_r;
    assign active_blanking_set4 = act_blank4_r;
    assign active_cross_conduction_set4 = act_xcond4_r;
    assign active_blanking_set3 = act_blank3_r;
    assign max_drive_current_ch1 = imax1_r;
    assign max_drive_current_ch2 = imax2_r;
    assign max_drive_current_ch3 = imax3_r;
    assign turn_on_delay_ch1 = ton1_r;
    assign turn_on_delay_ch2 = ton2_r;
    assign turn_on_delay_ch3 = ton3_r;
    assign turn_off_delay_ch1 = toff1_r;
    assign turn_off_delay_ch2 = toff2_r;
    assign turn_off_delay_ch3 = toff3_r;
    assign reg_rdata = rdata_r;
    assign reg_hit = hit_r;
endmodule

// ### test/gdt_host.sv
// host model issuing register accesses to the timing slice
`timescale 1ns/10ps
module gdt_host (
    input wire logic clk_sys,
    output logic reg_bank,
    output logic [4:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata
);
    initial {reg_bank, reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
    task automatic acc(input logic b, input logic [4:0] a, input logic w, input logic [15:0] d);
        @(posedge clk_sys);
        reg_bank <= b;
        reg_addr <= a;
        reg_wr <= w;
        reg_rd <= !w;
        reg_wdata <= d;
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= 2'h0;
        reg_wdata <= ~d;
        #1;
    endtask
endmodule

// ### test/gdt_regs_chk.sv
// checker of the gate drive timing register slice
`timescale 1ns/10ps
module gdt_regs_chk (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reg_bank,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_hit,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic [2:0] freewheel_blanking_set4,
    input wire logic [2:0] freewheel_cross_conduction_set4,
    input wire logic [2:0] active_cross_conduction_set4,
    input wire logic [1:0] max_drive_current_ch1,
    input wire logic [7:0] turn_on_delay_ch1,
    input wire logic [7:0] turn_off_delay_ch1
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic mapped, fw_acc, act_wr;
    assign mapped = reg_addr >= 5'h0d && reg_addr <= 5'h10;
    assign fw_acc = reg_bank && reg_addr == 5'h0d;
    assign act_wr = reg_wr && !reg_bank && reg_addr == 5'h0d;
    hit_flag_a: assert property (reg_rd |=> reg_hit == $past(mapped)) else $error("bad hit");
    unmapped_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 16'h0) else $error("bad data");
    rsv_zero_a: assert property (reg_rd && reg_addr == 5'h0d |=> !reg_rdata[15]) else $error("bit set");
    fw_write_a: assert property (reg_wr && fw_acc |-> ##2
        {freewheel_blanking_set4, max_drive_current_ch1} == $past({reg_wdata[14:12], reg_wdata[1:0]}, 2)) else $error("fw");
    act_write_a: assert property (act_wr |-> ##2 active_cross_conduction_set4 == $past(reg_wdata[11:9], 2))
        else $error("act");
    bank_steer_a: assert property (act_wr ##1 !reg_wr |-> ##1 $stable(freewheel_cross_conduction_set4))
        else $error("steer");
    delay_write_a: assert property (reg_wr && reg_addr == 5'h0e |-> ##2
        {turn_off_delay_ch1, turn_on_delay_ch1} == $past(reg_wdata, 2)) else $error("delay");
    fw_read_a: assert property (reg_rd && fw_acc && !reg_wr && !$past(reg_wr) |=>
        reg_rdata[14:9] == $past({freewheel_blanking_set4, freewheel_cross_conduction_set4})) else $error("rd");
    cover property (reg_rd && fw_acc);
    cover property (act_wr);
    cover property (reg_rd && !mapped);
endmodule
bind gdt_regs gdt_regs_chk chk_u (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .reg_bank(reg_bank),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_hit(reg_hit),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .freewheel_blanking_set4(freewheel_blanking_set4),
    .freewheel_cross_conduction_set4(freewheel_cross_conduction_set4),
    .active_cross_conduction_set4(active_cross_conduction_set4),
    .max_drive_current_ch1(max_drive_current_ch1),
    .turn_on_delay_ch1(turn_on_delay_ch1),
    .turn_off_delay_ch1(turn_off_delay_ch1)
);

// ### test/gdt_regs_tb.sv
// self-checking bench for the gate drive timing registers
`timescale 1ns/10ps
module gdt_regs_tb;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic reg_bank, reg_wr, reg_rd, reg_hit;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [2:0] freewheel_blanking_set4, freewheel_cross_conduction_set4, freewheel_blanking_set3;
    logic [2:0] active_blanking_set4, active_cross_conduction_set4, active_blanking_set3;
    logic [1:0] max_drive_current_ch1, max_drive_current_ch2, max_drive_current_ch3;
    logic [7:0] turn_on_delay_ch1, turn_on_delay_ch2, turn_on_delay_ch3;
    logic [7:0] turn_off_delay_ch1, turn_off_delay_ch2, turn_off_delay_ch3;
    int miscompares = 0;
    int comparisons = 0;
    always #2 clk_sys = ~clk_sys;
    gdt_host host_u (.*);
    gdt_regs dut_u (.*);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic b, input logic [4:0] a, input logic [15:0] e, input logic h);
        host_u.acc(b, a, 1'b0, 16'h0);
        chk(reg_rdata, e);
        chk({15'h0, reg_hit}, {15'h0, h});
    endtask
    function automatic logic [15:0] fw_view();
        return {1'b0, freewheel_blanking_set4, freewheel_cross_conduction_set4, freewheel_blanking_set3,
            max_drive_current_ch3, max_drive_current_ch2, max_drive_current_ch1};
    endfunction
    task automatic t_reset();
        chk(fw_view(), 16'h4900);
        chk({turn_off_delay_ch2, turn_on_delay_ch3}, 16'h0a0a);
        rd(1'b1, 5'h0d, 16'h4900, 1'b1);
        for (int i = 0; i < 3; i++) rd(1'b0, 5'(5'h0e + i), 16'h0a0a, 1'b1);
        $display("test reset done");
    endtask
    task automatic t_bank();
        host_u.acc(1'b1, 5'h0d, 1'b1, 16'hffe4);
        host_u.acc(1'b0, 5'h0d, 1'b1, 16'h1234);
        @(posedge clk_sys) #1;
        chk(fw_view(), 16'h7fe4);
        chk({7'h0, active_blanking_set4, active_cross_conduction_set4, active_blanking_set3}, 16'h0048);
        rd(1'b1, 5'h0d, 16'h7fe4, 1'b1);
        rd(1'b0, 5'h0d, 16'h1234, 1'b1);
        host_u.acc(1'b1, 5'h0d, 1'b1, 16'h803f);
        rd(1'b1, 5'h0d, 16'h003f, 1'b1);
        $display("test bank done");
    endtask
    task automatic t_delay();
        host_u.acc(1'b0, 5'h0e, 1'b1, 16'hff00);
        host_u.acc(1'b0, 5'h0f, 1'b1, 16'h00ff);
        host_u.acc(1'b0, 5'h10, 1'b1, 16'h8001);
        @(posedge clk_sys) #1;
        chk({turn_off_delay_ch1, turn_on_delay_ch1}, 16'hff00);
        chk({turn_off_delay_ch2, turn_on_delay_ch2}, 16'h00ff);
        chk({turn_off_delay_ch3, turn_on_delay_ch3}, 16'h8001);
        rd(1'b1, 5'h0f, 16'h00ff, 1'b1);
        host_u.acc(1'b1, 5'h11, 1'b1, 16'hffff);
        rd(1'b1, 5'h11, 16'h0, 1'b0);
        rd(1'b0, 5'h0c, 16'h0, 1'b0);
        rd(1'b0, 5'h10, 16'h8001, 1'b1);
        $display("test delay done");
    endtask
    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_bank();
        t_delay();
        end_of_test();
    end
    initial begin
        #4000;
        miscompares++;
        end_of_test();
    end
endmodule
